/* File: verilog/rsd_pkg.sv */
// Summary of operation
// RULE1: Rotate right through carry into working register
// RULE2: Rotate keeps memory, changes only carry
// RULE3: Working register minus memory minus inverted carry
// RULE4: Carry cleared on negative, set otherwise
// RULE5: Borrow subtract result written to memory
// RULE6: Subtracts update six arithmetic flags
// RULE7: Decrement memory, write back, skip on zero
// RULE8: Taken skip takes three instruction cycles
// RULE9: Decrement into working register, memory kept
// RULE10: Non-zero decrement continues without skipping
// RULE11: Decrement-and-skip leaves all flags unchanged
package rsd_pkg;

    typedef enum logic [2:0] {
        OP_ROT_RC_WREG = 3'h0,
        OP_SUB_BRW_WREG = 3'h1,
        OP_SUB_BRW_MEM = 3'h2,
        OP_DEC_SKZ_MEM = 3'h3,
        OP_DEC_SKZ_WREG = 3'h4
    } rsd_op_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_DUMMY = 1'b1
    } rsd_st_type;

    // Flag vector bit positions
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SC = 4;
    localparam int FLG_CZ = 5;

    localparam logic [5:0] FLAGS_NONE = 6'h00;
    localparam logic [5:0] FLAGS_CARRY = 6'h01;
    localparam logic [5:0] FLAGS_ALL = 6'h3F;

    // Busy cycles of a taken skip, counting the result cycle itself
    localparam logic [1:0] DUMMY_CYCLES = 2'h2;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;

endpackage

/* File: verilog/rsd_calc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface rsd_calc_if;
    import rsd_pkg::*;
    rsd_op_type op;
    logic [7:0] mem;
    logic [7:0] wreg;
    logic carry;
    logic cz_in;
    logic [7:0] result;
    logic [5:0] flags;
    logic [5:0] flags_we;
    logic to_wreg;
    logic to_mem;
    logic skip;

    modport calc (
        input op, mem, wreg, carry, cz_in,
        output result, flags, flags_we, to_wreg, to_mem, skip
    );
    modport core (
        output op, mem, wreg, carry, cz_in,
        input result, flags, flags_we, to_wreg, to_mem, skip
    );
endinterface
`default_nettype wire

/* File: verilog/rsd_calc.sv */
`timescale 1ns/1ns
`default_nettype none
module rsd_calc
    import rsd_pkg::*;
(
    rsd_calc_if.calc cif
);

    logic [8:0] diff;
    logic [4:0] low_diff;

    function automatic logic is_zero(input logic [7:0] value);
        return value == BYTE_ZERO;
    endfunction

    // RULE3: borrow inclusive difference
    assign diff = {1'b0, cif.wreg} - {1'b0, cif.mem} - {8'h00, ~cif.carry};
    assign low_diff = {1'b0, cif.wreg[3:0]} - {1'b0, cif.mem[3:0]} - {4'h0, ~cif.carry};

    always_comb begin
        cif.result = BYTE_ZERO;
        cif.flags = FLAGS_NONE;
        cif.flags_we = FLAGS_NONE;
        cif.to_wreg = 1'b0;
        cif.to_mem = 1'b0;
        cif.skip = 1'b0;
        unique case (cif.op)
            OP_ROT_RC_WREG: begin
                // RULE1: rotate through carry
                cif.result = {cif.carry, cif.mem[7:1]};
                cif.flags[FLG_C] = cif.mem[0];
                // RULE2: only carry written
                cif.flags_we = FLAGS_CARRY;
                cif.to_wreg = 1'b1;
            end
            OP_SUB_BRW_WREG, OP_SUB_BRW_MEM: begin
                cif.result = diff[7:0];
                // RULE4: carry means no borrow
                cif.flags[FLG_C] = ~diff[8];
                // RULE6: six flags updated
                cif.flags[FLG_AC] = ~low_diff[4];
                cif.flags[FLG_Z] = is_zero(diff[7:0]);
                cif.flags[FLG_OV] = (cif.wreg[7] != cif.mem[7]) && (diff[7] != cif.wreg[7]);
                cif.flags[FLG_SC] = (cif.wreg[7] != cif.mem[7]) ? cif.wreg[7] : diff[7];
                cif.flags[FLG_CZ] = is_zero(diff[7:0]) && cif.cz_in;
                cif.flags_we = FLAGS_ALL;
                // RULE5: destination select
                cif.to_wreg = (cif.op == OP_SUB_BRW_WREG);
                cif.to_mem = (cif.op == OP_SUB_BRW_MEM);
            end
            OP_DEC_SKZ_MEM, OP_DEC_SKZ_WREG: begin
                // RULE11: flags left alone
                cif.flags_we = FLAGS_NONE;
                // RULE7: decrement and test
                cif.result = cif.mem - BYTE_ONE;
                cif.skip = (cif.mem == BYTE_ONE);
                // RULE9: destination select
                cif.to_wreg = (cif.op == OP_DEC_SKZ_WREG);
                cif.to_mem = (cif.op == OP_DEC_SKZ_MEM);
            end
            default: begin
                cif.result = BYTE_ZERO;
            end
        endcase
    end

endmodule // rsd_calc
`default_nettype wire

/* File: verilog/rsd_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module rsd_alu
    import rsd_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic OP_VALID_I,
    input wire logic [2:0] OP_CODE_I,
    input wire logic [7:0] MEM_DATA_I,
    input wire logic [7:0] WREG_I,
    input wire logic CARRY_I,
    input wire logic CZ_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic WREG_WE_O,
    output logic [7:0] WREG_DATA_O,
    output logic MEM_WE_O,
    output logic [7:0] MEM_DATA_O,
    output logic [5:0] FLAGS_WE_O,
    output logic [5:0] FLAGS_O,
    output logic SKIP_O
);

    typedef struct packed {
        rsd_st_type st;
        logic [1:0] cnt;
        logic busy;
        logic done;
        logic wreg_we;
        logic [7:0] wreg_data;
        logic mem_we;
        logic [7:0] mem_data;
        logic [5:0] flags_we;
        logic [5:0] flags;
        logic skip;
    } rsd_state_type;

    localparam rsd_state_type STATE_RESET = '{
        st: ST_IDLE, cnt: CNT_ZERO, busy: 1'b0, done: 1'b0, wreg_we: 1'b0,
        wreg_data: BYTE_ZERO, mem_we: 1'b0, mem_data: BYTE_ZERO,
        flags_we: FLAGS_NONE, flags: FLAGS_NONE, skip: 1'b0
    };

    rsd_state_type state_q;
    rsd_state_type state_d;
    logic accept;

    rsd_calc_if cif ();

    assign accept = OP_VALID_I && !state_q.busy;
    assign cif.op = rsd_op_type'(OP_CODE_I);
    assign cif.mem = MEM_DATA_I;
    assign cif.wreg = WREG_I;
    assign cif.carry = CARRY_I;
    assign cif.cz_in = CZ_I;

    rsd_calc u_calc (
        .cif(cif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.wreg_we = 1'b0;
        state_d.mem_we = 1'b0;
        state_d.flags_we = FLAGS_NONE;
        state_d.skip = 1'b0;
        unique case (state_q.st)
            ST_IDLE: begin
                if (accept) begin
                    state_d.done = 1'b1;
                    state_d.wreg_we = cif.to_wreg;
                    state_d.mem_we = cif.to_mem;
                    state_d.wreg_data = cif.result;
                    state_d.mem_data = cif.result;
                    state_d.flags_we = cif.flags_we;
                    state_d.flags = cif.flags;
                    // RULE10: skip only on zero
                    state_d.skip = cif.skip;
                    // RULE8: dummy cycles follow
                    if (cif.skip) begin
                        state_d.st = ST_DUMMY;
                        state_d.cnt = DUMMY_CYCLES;
                        state_d.busy = 1'b1;
                    end
                end
            end
            ST_DUMMY: begin
                state_d.cnt = state_q.cnt - CNT_ONE;
                if (state_q.cnt == CNT_ONE) begin
                    state_d.st = ST_IDLE;
                    state_d.busy = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign BUSY_O = state_q.busy;
    assign DONE_O = state_q.done;
    assign WREG_WE_O = state_q.wreg_we;
    assign WREG_DATA_O = state_q.wreg_data;
    assign MEM_WE_O = state_q.mem_we;
    assign MEM_DATA_O = state_q.mem_data;
    assign FLAGS_WE_O = state_q.flags_we;
    assign FLAGS_O = state_q.flags;
    assign SKIP_O = state_q.skip;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic acc_rot;
    logic acc_sbw;
    logic acc_sbm;
    logic acc_dzm;
    logic acc_dzw;
    logic [8:0] exp_diff;
    logic [8:0] exp_sdiff;
    logic exp_nib_ok;

    assign acc_rot = accept && (OP_CODE_I == OP_ROT_RC_WREG);
    assign acc_sbw = accept && (OP_CODE_I == OP_SUB_BRW_WREG);
    assign acc_sbm = accept && (OP_CODE_I == OP_SUB_BRW_MEM);
    assign acc_dzm = accept && (OP_CODE_I == OP_DEC_SKZ_MEM);
    assign acc_dzw = accept && (OP_CODE_I == OP_DEC_SKZ_WREG);
    assign exp_diff = {1'b0, WREG_I} - {1'b0, MEM_DATA_I} - {8'h00, ~CARRY_I};
    // Sign-extended operands give the true signed result in nine bits
    assign exp_sdiff = {WREG_I[7], WREG_I} - {MEM_DATA_I[7], MEM_DATA_I} - {8'h00, ~CARRY_I};
    assign exp_nib_ok = {1'b0, WREG_I[3:0]} >= {1'b0, MEM_DATA_I[3:0]} + {4'h0, ~CARRY_I};

    property p_rot_value;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_rot |=> WREG_WE_O && WREG_DATA_O == {$past(CARRY_I), $past(MEM_DATA_I[7:1])}
            && FLAGS_O[FLG_C] == $past(MEM_DATA_I[0]);
    endproperty
    a_rot_value: assert property (p_rot_value) else $error("rotate result wrong"); // RULE1

    property p_rot_side;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_rot |=> !MEM_WE_O && FLAGS_WE_O == FLAGS_CARRY;
    endproperty
    a_rot_side: assert property (p_rot_side) else $error("rotate side effect"); // RULE2

    property p_sbw_value;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_sbw |=> WREG_WE_O && !MEM_WE_O && WREG_DATA_O == $past(exp_diff[7:0]);
    endproperty
    a_sbw_value: assert property (p_sbw_value) else $error("subtract to wreg wrong"); // RULE3

    property p_sb_carry;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (acc_sbw || acc_sbm) |=> FLAGS_O[FLG_C] == !$past(exp_diff[8]);
    endproperty
    a_sb_carry: assert property (p_sb_carry) else $error("subtract carry wrong"); // RULE4

    property p_sbm_value;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_sbm |=> MEM_WE_O && !WREG_WE_O && MEM_DATA_O == $past(exp_diff[7:0]);
    endproperty
    a_sbm_value: assert property (p_sbm_value) else $error("subtract to mem wrong"); // RULE5

    property p_sb_flags;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (acc_sbw || acc_sbm) |=> FLAGS_WE_O == FLAGS_ALL
            && FLAGS_O[FLG_Z] == ($past(exp_diff[7:0]) == BYTE_ZERO);
    endproperty
    a_sb_flags: assert property (p_sb_flags) else $error("subtract flags wrong"); // RULE6

    property p_sb_arith;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (acc_sbw || acc_sbm) |=> FLAGS_O[FLG_SC] == $past(exp_sdiff[8])
            && FLAGS_O[FLG_OV] == ($past(exp_sdiff[8]) != $past(exp_sdiff[7]))
            && FLAGS_O[FLG_AC] == $past(exp_nib_ok)
            && FLAGS_O[FLG_CZ] == ($past(CZ_I) && $past(exp_diff[7:0]) == BYTE_ZERO);
    endproperty
    a_sb_arith: assert property (p_sb_arith) else $error("subtract sign flags wrong"); // RULE6

    property p_dzm_value;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_dzm |=> MEM_WE_O && MEM_DATA_O == $past(MEM_DATA_I) - BYTE_ONE
            && SKIP_O == ($past(MEM_DATA_I) == BYTE_ONE);
    endproperty
    a_dzm_value: assert property (p_dzm_value) else $error("decrement to mem wrong"); // RULE7

    sequence s_dummy;
        BUSY_O [*2] ##1 !BUSY_O;
    endsequence

    property p_skip_cycles;
        @(posedge CLK_I) disable iff (!RST_N_I)
        SKIP_O |-> s_dummy;
    endproperty
    a_skip_cycles: assert property (p_skip_cycles) else $error("skip length wrong"); // RULE8

    property p_refused;
        @(posedge CLK_I) disable iff (!RST_N_I)
        OP_VALID_I && BUSY_O |=> !DONE_O;
    endproperty
    a_refused: assert property (p_refused) else $error("request taken while busy"); // RULE8

    property p_busy_start;
        @(posedge CLK_I) disable iff (!RST_N_I)
        $rose(BUSY_O) |-> SKIP_O && DONE_O;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without skip"); // RULE10

    property p_dzw_value;
        @(posedge CLK_I) disable iff (!RST_N_I)
        acc_dzw |=> WREG_WE_O && !MEM_WE_O && WREG_DATA_O == $past(MEM_DATA_I) - BYTE_ONE;
    endproperty
    a_dzw_value: assert property (p_dzw_value) else $error("decrement to wreg wrong"); // RULE9

    property p_no_skip;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (acc_dzm || acc_dzw) && MEM_DATA_I != BYTE_ONE |=> DONE_O && !SKIP_O && !BUSY_O;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("spurious skip"); // RULE10

    property p_dz_flags;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (acc_dzm || acc_dzw) |=> FLAGS_WE_O == FLAGS_NONE;
    endproperty
    a_dz_flags: assert property (p_dz_flags) else $error("decrement touched flags"); // RULE11

endmodule // rsd_alu
`default_nettype wire

/* File: test/rsd_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rsd_core_model
    import rsd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [7:0] ld_mem_i,
    input wire logic [7:0] ld_wreg_i,
    input wire logic [5:0] ld_flags_i,
    input wire logic wreg_we_i,
    input wire logic [7:0] wreg_data_i,
    input wire logic mem_we_i,
    input wire logic [7:0] mem_data_i,
    input wire logic [5:0] flags_we_i,
    input wire logic [5:0] flags_i,
    output logic [7:0] mem_o,
    output logic [7:0] wreg_o,
    output logic [5:0] flags_o
);
    // Memory byte, working register and status, updated from the write strobes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_o <= 8'h00;
            wreg_o <= 8'h00;
            flags_o <= 6'h00;
        end else if (load_i) begin
            mem_o <= ld_mem_i;
            wreg_o <= ld_wreg_i;
            flags_o <= ld_flags_i;
        end else begin
            if (mem_we_i) mem_o <= mem_data_i;
            if (wreg_we_i) wreg_o <= wreg_data_i;
            flags_o <= (flags_o & ~flags_we_i) | (flags_i & flags_we_i);
        end
    end
endmodule // rsd_core_model
`default_nettype wire

/* File: test/rotate_subtract_decskip_alu_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module rotate_subtract_decskip_alu_bench;
    import rsd_pkg::*;
    logic clk, rst_n, load, op_valid, busy, done, wwe, mwe, skip;
    logic [2:0] op_code;
    logic [7:0] ld_mem, ld_wreg, wdat, mdat, mem, wreg;
    logic [5:0] ld_flags, fwe, fout, flags;
    int failures, checked;
    ////////////////////////////////////////////////////////////////////////////
    rsd_alu u_dut (.CLK_I(clk), .RST_N_I(rst_n), .OP_VALID_I(op_valid), .OP_CODE_I(op_code),
        .MEM_DATA_I(mem), .WREG_I(wreg), .CARRY_I(flags[FLG_C]), .CZ_I(flags[FLG_CZ]),
        .BUSY_O(busy), .DONE_O(done), .WREG_WE_O(wwe), .WREG_DATA_O(wdat), .MEM_WE_O(mwe),
        .MEM_DATA_O(mdat), .FLAGS_WE_O(fwe), .FLAGS_O(fout), .SKIP_O(skip));
    rsd_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .load_i(load), .ld_mem_i(ld_mem),
        .ld_wreg_i(ld_wreg), .ld_flags_i(ld_flags), .wreg_we_i(wwe), .wreg_data_i(wdat),
        .mem_we_i(mwe), .mem_data_i(mdat), .flags_we_i(fwe), .flags_i(fout), .mem_o(mem),
        .wreg_o(wreg), .flags_o(flags));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Preload core state, issue one request, return in the result cycle
    task automatic do_op(input logic [2:0] op, input logic [7:0] m, w, input logic [5:0] f);
        @(posedge clk);
        ld_mem <= m;
        ld_wreg <= w;
        ld_flags <= f;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        op_valid <= 1'b1;
        op_code <= op;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("done", 8'h01, {7'h00, done});
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
        chk("done_drop", 8'h00, {7'h00, done});
    endtask
    task automatic t_rot(input logic [7:0] m, input logic c);
        do_op(OP_ROT_RC_WREG, m, 8'h5A, {6'h20 | {5'h00, c}});
        chk("rot_fwe", {2'h0, FLAGS_CARRY}, {2'h0, fwe});
        settle();
        chk("rot_wreg", {c, m[7:1]}, wreg);
        chk("rot_c", {7'h00, m[0]}, {7'h00, flags[FLG_C]});
        chk("rot_mem", m, mem);
        chk("rot_flags", {2'h0, 5'h10, m[0]}, {2'h0, flags});
    endtask
    task automatic t_sub(input logic [2:0] op, input logic [7:0] w, m, input logic c, cz);
        logic [8:0] d;
        int sv;
        logic ac_exp;
        d = {1'b0, w} - {1'b0, m} - {8'h00, ~c};
        sv = $signed(w) - $signed(m) - (c ? 0 : 1);
        ac_exp = int'(w[3:0]) >= int'(m[3:0]) + (c ? 0 : 1);
        do_op(op, m, w, {cz, 4'h0, c});
        chk("sub_fwe", {2'h0, FLAGS_ALL}, {2'h0, fwe});
        chk("sub_c", {7'h00, ~d[8]}, {7'h00, fout[FLG_C]});
        chk("sub_z", {7'h00, d[7:0] == 8'h00}, {7'h00, fout[FLG_Z]});
        chk("sub_cz", {7'h00, cz && d[7:0] == 8'h00}, {7'h00, fout[FLG_CZ]});
        chk("sub_ac", {7'h00, ac_exp}, {7'h00, fout[FLG_AC]});
        chk("sub_ov", {7'h00, sv > 127 || sv < -128}, {7'h00, fout[FLG_OV]});
        chk("sub_sc", {7'h00, sv < 0}, {7'h00, fout[FLG_SC]});
        settle();
        chk("sub_wreg", op == OP_SUB_BRW_WREG ? d[7:0] : w, wreg);
        chk("sub_mem", op == OP_SUB_BRW_MEM ? d[7:0] : m, mem);
    endtask
    task automatic t_dec(input logic [2:0] op, input logic [7:0] m);
        logic sk;
        sk = (m - 8'h01) == 8'h00;
        do_op(op, m, 8'hC3, 6'h2A);
        chk("dec_skip", {7'h00, sk}, {7'h00, skip});
        chk("dec_fwe", 8'h00, {2'h0, fwe});
        chk("dec_busy1", {7'h00, sk}, {7'h00, busy});
        settle();
        chk("dec_busy2", {7'h00, sk}, {7'h00, busy});
        chk("dec_mem", op == OP_DEC_SKZ_MEM ? m - 8'h01 : m, mem);
        chk("dec_wreg", op == OP_DEC_SKZ_WREG ? m - 8'h01 : 8'hC3, wreg);
        chk("dec_flags", 8'h2A, {2'h0, flags});
        @(posedge clk);
        #1;
        chk("dec_busy3", 8'h00, {7'h00, busy});
    endtask
    // A request held through the dummy cycles is taken only after them
    task automatic t_refuse();
        @(posedge clk);
        ld_mem <= 8'h01;
        ld_wreg <= 8'h77;
        ld_flags <= 6'h01;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        op_valid <= 1'b1;
        op_code <= OP_DEC_SKZ_MEM;
        @(posedge clk);
        op_code <= OP_ROT_RC_WREG;
        #1;
        chk("ref_skip", 8'h01, {7'h00, skip});
        repeat (2) begin
            @(posedge clk);
            #1;
            chk("ref_done", 8'h00, {7'h00, done});
        end
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("ref_taken", 8'h01, {7'h00, done});
        chk("ref_wdat", 8'h80, wdat);
        settle();
        chk("ref_wreg", 8'h80, wreg);
        chk("ref_mem", 8'h00, mem);
    endtask
    // Reset in the middle of the dummy cycles drops busy at once
    task automatic t_reset();
        do_op(OP_DEC_SKZ_WREG, 8'h01, 8'h3C, 6'h15);
        chk("pre_busy", 8'h01, {7'h00, busy});
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk("rst_busy", 8'h00, {7'h00, busy});
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) begin
            @(posedge clk);
            #1;
            chk("rel_busy", 8'h00, {7'h00, busy});
            chk("rel_done", 8'h00, {7'h00, done});
        end
    endtask
    task automatic print_verdict();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
    initial begin
        {rst_n, load, op_valid, op_code, ld_mem, ld_wreg, ld_flags} = '0;
        failures = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_rot(8'hA5, 1'b1);
        t_rot(8'h02, 1'b0);
        t_sub(OP_SUB_BRW_WREG, 8'h10, 8'h20, 1'b1, 1'b1);
        t_sub(OP_SUB_BRW_WREG, 8'h05, 8'h04, 1'b0, 1'b1);
        t_sub(OP_SUB_BRW_MEM, 8'h80, 8'h01, 1'b1, 1'b0);
        t_sub(OP_SUB_BRW_MEM, 8'h00, 8'hFF, 1'b0, 1'b1);
        t_dec(OP_DEC_SKZ_MEM, 8'h01);
        t_dec(OP_DEC_SKZ_MEM, 8'h00);
        t_dec(OP_DEC_SKZ_WREG, 8'h01);
        t_dec(OP_DEC_SKZ_WREG, 8'h06);
        t_refuse();
        t_reset();
        t_rot(8'h3C, 1'b1);
        print_verdict();
    end
endmodule // rotate_subtract_decskip_alu_bench
`default_nettype wire
